// file: verilog/selog_pkg.sv
// constants for the stream error log keeper
package selog_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] EV_FEAT_OFS = 12'h004;
    localparam logic [11:0] EV_SHADOW0_OFS = 12'h008;
    localparam logic [11:0] EV_SHADOW1_OFS = 12'h00c;
    localparam logic [11:0] EV_LBA_LO_OFS = 12'h010;
    localparam logic [11:0] EV_LBA_HI_OFS = 12'h014;
    localparam logic [11:0] EV_CMD_OFS = 12'h018;
    localparam logic [11:0] STATUS_OFS = 12'h01c;
    localparam logic [11:0] ST_LBA_LO_OFS = 12'h020;
    localparam logic [11:0] ST_INFO_OFS = 12'h024;
    localparam logic [11:0] ST_LBA_HI_OFS = 12'h028;
    localparam logic [11:0] RD_PAGE_BASE = 12'h400;
    localparam logic [11:0] WR_PAGE_BASE = 12'h600;
    localparam logic [11:0] CE_PAGE_BASE = 12'h800;
    localparam logic [11:0] ST_DESC_BASE = 12'ha00;
    // ****************************************
    // control bits and log addresses
    // ****************************************
    localparam int CTRL_LOG_RD_BIT = 0;
    localparam int CTRL_LOG_WR_BIT = 1;
    localparam int CTRL_CMD_ERR_BIT = 2;
    localparam int CTRL_DEFER_BIT = 3;
    localparam int CTRL_SE_BIT = 4;
    localparam int CTRL_NQ_BIT = 5;
    localparam int CTRL_DONE_BIT = 8;
    localparam int CTRL_ADDR_LSB = 16;
    localparam logic [7:0] RD_LOG_ADDR = 8'h22;
    localparam logic [7:0] WR_LOG_ADDR = 8'h21;
    // ****************************************
    // page layout
    // ****************************************
    localparam logic [7:0] PAGE_VERSION = 8'h02;
    localparam logic [4:0] MAX_ENTRIES = 5'd31;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] DEFER_FEATURE = 16'hffff;
    localparam int ENTRY_BYTES = 16;
    localparam int DESC_BYTES = 26;
    localparam int CMD_ERR_LAST = 511;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: verilog/stream_log_store.sv
// one stream error page: entry ring, index and saturating count
`timescale 1ns/10ps
`default_nettype none
module stream_log_store
    import selog_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // event and clear
    input wire logic add,
    input wire logic clear,
    input wire logic [127:0] entry,
    // page read port
    input wire logic [6:0] word_sel,
    output logic [31:0] word,
    output logic [4:0] index,
    output logic [15:0] count
);
    logic [127:0] slot_q [1:31];
    logic [30:0] used_q;
    logic [4:0] idx_q;
    logic [15:0] cnt_q;
    logic [4:0] next_idx;

    // advance index with wrap to first
    assign next_idx = (idx_q == MAX_ENTRIES) ? 5'd1 : idx_q + 5'd1;

    always_ff @(posedge aclk) begin
        if (add) begin
            slot_q[next_idx] <= entry;
        end
    end

    // used mask makes empty slots read zero
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            used_q <= '0;
        end else if (add) begin
            used_q[next_idx - 5'd1] <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            idx_q <= '0;
        end else if (add) begin
            idx_q <= next_idx;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_q <= '0;
        end else if (add && cnt_q != COUNT_MAX) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // header then entries from word 4
    // version byte fixed in header word
    always_comb begin
        word = '0;
        if (word_sel == 7'h00) begin
            word = {cnt_q, 3'b000, idx_q, PAGE_VERSION};
        end else if (word_sel[6:2] != 5'd0 && used_q[word_sel[6:2] - 5'd1]) begin
            word = slot_q[word_sel[6:2]][32*word_sel[1:0] +: 32];
        end
    end
    assign index = idx_q;
    assign count = cnt_q;

    cnt_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_q == COUNT_MAX && !clear |=> cnt_q == COUNT_MAX)
        else $error("count left saturation");
    clr_idx_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clear |=> idx_q == 5'd0 && cnt_q == 16'h0000)
        else $error("clear did not reset log");
    idx_rng_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (idx_q == 5'd0) == (cnt_q == 16'h0000))
        else $error("index zero while errors logged");
    idx_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        add && !clear && idx_q == MAX_ENTRIES |=> idx_q == 5'd1)
        else $error("index did not wrap");
endmodule
`default_nettype wire

// file: verilog/stream_error_log_keeper.sv
// stream error log keeper with axi4-lite register access
// Summary of operation
// - self-test descriptor is 26 bytes, fixed fields
// - queued failure puts tag in bits 4:0
// - byte zero bit seven marks non-queued
// - bytes 2-13 snapshot shadow registers
// - last byte makes page sum zero
// - read entry only when stream flag set
// - read page keeps newest 31 entries
// - read count totals errors since 22h read
// - read count saturates at maximum
// - read of 22h clears read log
// - read log empty after reset
// - page header version, index, count, entries
// - version byte reads 02h
// - read index points newest, 0 to 31
// - entry holds features, status, error, lba, count
// - deferred write loads all-ones features
// - entry gives start lba and length
// - write log records with flag, counts errors
// - read of 21h clears write log
// - write index newest entry, 0 to 31
// - write page 31 entries, same layout
// - ring overwrites oldest, empty slots zero
`timescale 1ns/10ps
`default_nettype none
module stream_error_log_keeper
    import selog_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // ****************************************
    // event capture registers
    // ****************************************
    logic [31:0] feat_q, sh0_q, sh1_q, lba_lo_q, lba_hi_q, cmd_q;
    logic [31:0] st_lba_lo_q, st_info_q, st_lba_hi_q;
    logic [7:0] ce_q [0:15];
    logic [7:0] ce_sum_q;
    logic aw_q, w_q;
    logic [11:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_go, rd_add, wr_add, rd_clr, wr_clr, ce_go;
    logic [127:0] ev_entry;
    logic [31:0] rd_word, wr_word;
    logic [4:0] rd_idx, wr_idx;
    logic [15:0] rd_cnt, wr_cnt;
    logic [31:0] rd_data_d;
    logic [1:0] rd_resp_d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // hold address and data until both taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                awa_q <= awaddr;
            end else if (wr_go) begin
                aw_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wd_q <= wdata;
                ws_q <= wstrb;
            end else if (wr_go) begin
                w_q <= 1'b0;
            end
        end
    end
    assign wr_go = aw_q && w_q && !bvalid;

    // ready flops drop once each channel is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !aw_q && !(awvalid && awready) && !bvalid;
            wready <= !w_q && !(wvalid && wready) && !bvalid;
        end
    end

    // write response, slverr outside control space
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= (awa_q[11:2] <= ST_LBA_HI_OFS[11:2]) ? RESP_OKAY
                                                            : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // event registers and control strobes
    // ****************************************
    // byte-enabled stores of event fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            feat_q <= '0;
            sh0_q <= '0;
            sh1_q <= '0;
            lba_lo_q <= '0;
            lba_hi_q <= '0;
            cmd_q <= '0;
            st_lba_lo_q <= '0;
            st_info_q <= '0;
            st_lba_hi_q <= '0;
        end else if (wr_go) begin
            case (awa_q)
                EV_FEAT_OFS: feat_q <= merge(feat_q, wd_q, ws_q);
                EV_SHADOW0_OFS: sh0_q <= merge(sh0_q, wd_q, ws_q);
                EV_SHADOW1_OFS: sh1_q <= merge(sh1_q, wd_q, ws_q);
                EV_LBA_LO_OFS: lba_lo_q <= merge(lba_lo_q, wd_q, ws_q);
                EV_LBA_HI_OFS: lba_hi_q <= merge(lba_hi_q, wd_q, ws_q);
                EV_CMD_OFS: cmd_q <= merge(cmd_q, wd_q, ws_q);
                ST_LBA_LO_OFS: st_lba_lo_q <= merge(st_lba_lo_q, wd_q, ws_q);
                ST_INFO_OFS: st_info_q <= merge(st_info_q, wd_q, ws_q);
                ST_LBA_HI_OFS: st_lba_hi_q <= merge(st_lba_hi_q, wd_q, ws_q);
                default: ;
            endcase
        end
    end

    // stream entry needs flag bit set
    // write log also gated by flag
    assign rd_add = wr_go && awa_q == CTRL_OFS && ws_q[0]
        && wd_q[CTRL_LOG_RD_BIT] && wd_q[CTRL_SE_BIT];
    assign wr_add = wr_go && awa_q == CTRL_OFS && ws_q[0]
        && wd_q[CTRL_LOG_WR_BIT] && wd_q[CTRL_SE_BIT];
    assign ce_go = wr_go && awa_q == CTRL_OFS && ws_q[0]
        && wd_q[CTRL_CMD_ERR_BIT];
    // successful 22h page read clears read log
    // successful 21h page read clears write log
    assign rd_clr = wr_go && awa_q == CTRL_OFS && ws_q[1] && ws_q[2]
        && wd_q[CTRL_DONE_BIT]
        && wd_q[CTRL_ADDR_LSB +: 8] == RD_LOG_ADDR;
    assign wr_clr = wr_go && awa_q == CTRL_OFS && ws_q[1] && ws_q[2]
        && wd_q[CTRL_DONE_BIT]
        && wd_q[CTRL_ADDR_LSB +: 8] == WR_LOG_ADDR;

    // deferred write forces features to ones
    always_comb begin
        ev_entry = '0;
        ev_entry[15:0] = wd_q[CTRL_DEFER_BIT] ? DEFER_FEATURE
                                              : feat_q[15:0];
        ev_entry[23:16] = sh0_q[7:0];
        ev_entry[31:24] = sh0_q[15:8];
        ev_entry[79:32] = {lba_hi_q[15:0], lba_lo_q};
        ev_entry[111:96] = feat_q[31:16];
    end

    // ****************************************
    // command error record
    // ****************************************
    // bit seven non-queued; tag in 4:0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                ce_q[i] <= '0;
            end
        end else if (ce_go) begin
            ce_q[0] <= {wd_q[CTRL_NQ_BIT], 2'b00,
                        wd_q[CTRL_NQ_BIT] ? 5'h00 : cmd_q[4:0]};
            ce_q[1] <= 8'h00;
            {ce_q[5], ce_q[4], ce_q[3], ce_q[2]} <= sh0_q;
            {ce_q[9], ce_q[8], ce_q[7], ce_q[6]} <= sh1_q;
            ce_q[10] <= cmd_q[15:8];
            ce_q[11] <= 8'h00;
            ce_q[12] <= feat_q[23:16];
            ce_q[13] <= feat_q[31:24];
        end
    end

    // checksum is negated sum of bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ce_sum_q <= '0;
        end else if (ce_go) begin
            ce_sum_q <= 8'h00 - ({wd_q[CTRL_NQ_BIT], 7'h00}
                + (wd_q[CTRL_NQ_BIT] ? 8'h00 : {3'b000, cmd_q[4:0]})
                + sh0_q[7:0] + sh0_q[15:8] + sh0_q[23:16] + sh0_q[31:24]
                + sh1_q[7:0] + sh1_q[15:8] + sh1_q[23:16] + sh1_q[31:24]
                + cmd_q[15:8] + feat_q[23:16] + feat_q[31:24]);
        end
    end

    // ****************************************
    // stream logs
    // ****************************************
    // both logs start empty from reset
    stream_log_store u_rd_log (
        .aclk(aclk),
        .aresetn(aresetn),
        .add(rd_add),
        .clear(rd_clr),
        .entry(ev_entry),
        .word_sel(araddr[8:2]),
        .word(rd_word),
        .index(rd_idx),
        .count(rd_cnt)
    );
    stream_log_store u_wr_log (
        .aclk(aclk),
        .aresetn(aresetn),
        .add(wr_add),
        .clear(wr_clr),
        .entry(ev_entry),
        .word_sel(araddr[8:2]),
        .word(wr_word),
        .index(wr_idx),
        .count(wr_cnt)
    );

    // ****************************************
    // read decode
    // ****************************************
    // descriptor bytes 0-10 then vendor zeros
    always_comb begin
        rd_data_d = '0;
        rd_resp_d = RESP_OKAY;
        case (araddr[11:9])
            3'h0: begin
                case (araddr[8:0])
                    9'(CTRL_OFS): rd_data_d = '0;
                    9'(EV_FEAT_OFS): rd_data_d = feat_q;
                    9'(EV_SHADOW0_OFS): rd_data_d = sh0_q;
                    9'(EV_SHADOW1_OFS): rd_data_d = sh1_q;
                    9'(EV_LBA_LO_OFS): rd_data_d = lba_lo_q;
                    9'(EV_LBA_HI_OFS): rd_data_d = lba_hi_q;
                    9'(EV_CMD_OFS): rd_data_d = cmd_q;
                    9'(STATUS_OFS): rd_data_d = {wr_cnt[7:0], 3'b000, wr_idx,
                                                 rd_cnt[7:0], 3'b000, rd_idx};
                    9'(ST_LBA_LO_OFS): rd_data_d = st_lba_lo_q;
                    9'(ST_INFO_OFS): rd_data_d = st_info_q;
                    9'(ST_LBA_HI_OFS): rd_data_d = st_lba_hi_q;
                    default: rd_resp_d = RESP_SLVERR;
                endcase
            end
            3'h2: rd_data_d = rd_word;
            3'h3: rd_data_d = wr_word;
            3'h4: begin
                if (araddr[8:2] < 7'd4) begin
                    rd_data_d = {ce_q[4*araddr[3:2] + 3],
                                 ce_q[4*araddr[3:2] + 2],
                                 ce_q[4*araddr[3:2] + 1],
                                 ce_q[4*araddr[3:2]]} & (araddr[3:2] == 2'd3
                                 ? 32'h0000_ffff : 32'hffff_ffff);
                end else if (araddr[8:2] == 7'(CMD_ERR_LAST / 4)) begin
                    rd_data_d = {ce_sum_q, 24'h000000};
                end
            end
            3'h5: begin
                case (araddr[4:2])
                    3'd0: rd_data_d = st_info_q;
                    3'd1: rd_data_d = {st_lba_lo_q[23:0], st_lba_hi_q[31:24]};
                    3'd2: rd_data_d = {8'h00, st_lba_hi_q[15:0],
                                       st_lba_lo_q[31:24]};
                    default: rd_data_d = '0;
                endcase
            end
            default: rd_resp_d = RESP_SLVERR;
        endcase
    end

    // one-cycle read answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= rd_data_d;
                rresp <= rd_resp_d;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    rd_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !wd_q[CTRL_SE_BIT] && !rd_clr |=> rd_cnt == $past(rd_cnt))
        else $error("read log grew without flag");
    wr_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_add && !wr_clr && wr_cnt != COUNT_MAX
        |=> wr_cnt == $past(wr_cnt) + 16'd1)
        else $error("write count did not grow");
    wr_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_clr |=> wr_idx == 5'd0 && wr_cnt == 16'd0)
        else $error("write log not cleared");
    nq_tag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce_go && !wd_q[CTRL_NQ_BIT] |=> ce_q[0][4:0] == $past(cmd_q[4:0]))
        else $error("tag not captured");
    nq_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce_go |=> ce_q[0][7] == $past(wd_q[CTRL_NQ_BIT]))
        else $error("non-queued bit wrong");
    ce_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        8'(ce_q[0] + ce_q[2] + ce_q[3] + ce_q[4] + ce_q[5] + ce_q[6]
        + ce_q[7] + ce_q[8] + ce_q[9] + ce_q[10] + ce_q[12] + ce_q[13]
        + ce_sum_q) == 8'h00)
        else $error("checksum wrong");
    rd_wr_idx_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_idx == 5'd0) == (wr_cnt == 16'h0000))
        else $error("write index disagrees with count");
    resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
endmodule
`default_nettype wire

// file: test/axi_lite_host.sv
// axi4-lite host model that fetches log pages
`timescale 1ns/10ps
`default_nettype none
module axi_lite_host (
    // clock
    input wire logic aclk,
    // write request
    output logic awvalid,
    input wire logic awready,
    output logic [11:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    // write response
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read
    output logic arvalid,
    input wire logic arready,
    output logic [11:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        araddr = '0;
    end
    // one write: address and data together, then the response
    task automatic write_word(input logic [11:0] a, input logic [31:0] d,
                              output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(bvalid && aw_ok && w_ok));
        r = bresp;
        bready <= 1'b0;
    endtask
    // one read: hold the address until taken, data with rvalid
    task automatic read_word(input logic [11:0] a, output logic [31:0] d,
                             output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/tb_stream_error_log_keeper.sv
// testbench for the stream error log keeper
`timescale 1ns/10ps
`default_nettype none
module tb_stream_error_log_keeper;
    import selog_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    wire logic awvalid, awready, wvalid, wready, bvalid, bready;
    wire logic arvalid, arready, rvalid, rready;
    wire logic [11:0] awaddr, araddr;
    wire logic [31:0] wdata, rdata;
    wire logic [3:0] wstrb;
    wire logic [1:0] bresp, rresp;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    always #2 aclk = ~aclk;
    stream_error_log_keeper dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
    axi_lite_host host (.aclk(aclk),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
    // compare and count
    task automatic check(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.write_word(a, d, rs);
        check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    endtask
    task automatic rchk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
        host.read_word(a, rd, rs);
        check(n, rd, e);
    endtask
    task automatic add_ev(input logic [31:0] ctl, input logic [31:0] lba);
        wr(EV_LBA_LO_OFS, lba);
        wr(CTRL_OFS, ctl);
    endtask
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        final_report();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        do_reset();
        rchk("rd_page", RD_PAGE_BASE, 32'h0000_0002);
        rchk("wr_page", WR_PAGE_BASE, 32'h0000_0002);
        rchk("slot1", RD_PAGE_BASE + 12'h010, 32'h0);
        wr(EV_FEAT_OFS, 32'h0007_3412);
        wr(EV_SHADOW0_OFS, 32'h4433_5141);
        wr(EV_SHADOW1_OFS, 32'h8877_6655);
        wr(EV_LBA_HI_OFS, 32'h0000_beef);
        wr(EV_CMD_OFS, 32'h0000_9916);
        add_ev(32'h01, 32'h100);
        add_ev(32'h02, 32'h100);
        rchk("no_flag", STATUS_OFS, 32'h0);
        $display("test flag gate done");
        add_ev(32'h11, 32'h101);
        rchk("hdr1", RD_PAGE_BASE, 32'h0001_0102);
        rchk("e_w0", RD_PAGE_BASE + 12'h010, 32'h5141_3412);
        rchk("e_w1", RD_PAGE_BASE + 12'h014, 32'h101);
        rchk("e_w2", RD_PAGE_BASE + 12'h018, 32'hbeef);
        rchk("e_w3", RD_PAGE_BASE + 12'h01c, 32'h7);
        rchk("status1", STATUS_OFS, 32'h0000_0101);
        for (int i = 2; i <= 32; i++)
            add_ev(32'h11, 32'h100 + i);
        rchk("hdr32", RD_PAGE_BASE, 32'h0020_0102);
        rchk("wrapped", RD_PAGE_BASE + 12'h014, 32'h120);
        rchk("slot31", RD_PAGE_BASE + 12'h1f4, 32'h11f);
        $display("test read log done");
        // page checked above before the clearing read
        wr(CTRL_OFS, 32'h0022_0100);
        rchk("rd_clr", RD_PAGE_BASE, 32'h0000_0002);
        rchk("rd_clr_e", RD_PAGE_BASE + 12'h014, 32'h0);
        add_ev(32'h1a, 32'h200);
        rchk("whdr", WR_PAGE_BASE, 32'h0001_0102);
        rchk("w_feat", WR_PAGE_BASE + 12'h010, 32'h5141_ffff);
        rchk("w_lba", WR_PAGE_BASE + 12'h014, 32'h200);
        rchk("status2", STATUS_OFS, 32'h0101_0000);
        wr(CTRL_OFS, 32'h0021_0100);
        rchk("wr_clr", WR_PAGE_BASE, 32'h0000_0002);
        $display("test write log done");
        wr(CTRL_OFS, 32'h04);
        rchk("ce0", CE_PAGE_BASE, 32'h5141_0016);
        rchk("ce1", CE_PAGE_BASE + 12'h004, 32'h6655_4433);
        rchk("ce2", CE_PAGE_BASE + 12'h008, 32'h0099_8877);
        rchk("ce3", CE_PAGE_BASE + 12'h00c, 32'h0000_0007);
        host.read_word(CE_PAGE_BASE + 12'h1fc, rd, rs);
        check("ce_sum", {24'h0, rd[31:24]}, 32'h87);
        wr(CTRL_OFS, 32'h24);
        rchk("ce_nq", CE_PAGE_BASE, 32'h5141_0080);
        host.read_word(CE_PAGE_BASE + 12'h1fc, rd, rs);
        check("ce_sum_nq", {24'h0, rd[31:24]}, 32'h1d);
        $display("test command error done");
        wr(ST_LBA_LO_OFS, 32'hd4c3_b2a1);
        wr(ST_INFO_OFS, 32'h0123_4505);
        wr(ST_LBA_HI_OFS, 32'h9a00_f6e5);
        rchk("st0", ST_DESC_BASE, 32'h0123_4505);
        rchk("st1", ST_DESC_BASE + 12'h004, 32'hc3b2_a19a);
        host.read_word(ST_DESC_BASE + 12'h008, rd, rs);
        check("st2", {8'h0, rd[23:0]}, 32'hf6e5d4);
        $display("test self-test done");
        host.read_word(12'h030, rd, rs);
        check("bad_rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        check("bad_rdata", rd, 32'h0);
        host.write_word(12'h030, 32'h1, rs);
        check("bad_bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        add_ev(32'h11, 32'h300);
        do_reset();
        rchk("rst_page", RD_PAGE_BASE, 32'h0000_0002);
        rchk("rst_slot", RD_PAGE_BASE + 12'h014, 32'h0);
        $display("test unmapped and reset done");
        final_report();
    end
endmodule
`default_nettype wire
